// [verilog/pm_consts.svh]
// Constants for the measurement setup and shunt register block
// Notes on behaviour
// - Mode bits 15-12, reset Fh; 0h/8h shut down
// - Modes 1h-7h convert selected channels once
// - Modes 9h-Fh convert selected channels continuously once written, not from reset
// - Bus time bits 11-9, reset 5h, eight codes
// - Shunt time bits 8-6, same time codes
// - Temperature time bits 5-3, same time codes
// - Averaging bits 2-0, reset 0h, 1 to 1024
// - Averaging applies to every enabled channel
// - Results update only after averaging completes
// - Calibration bits 14-0, writable, reset 1000h
// - Reserved bits always read as zero
// - Drift coefficient bits 13-0, reset zero
// - Drift coefficient weighs one ppm per LSB
// - Shunt result signed, bits 23-4, reset zero
// - Result LSB weight follows range select
// - Range select picks shunt full scale
// - Drift coefficient used only while enabled
`ifndef PM_CONSTS_SVH
`define PM_CONSTS_SVH

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define ADDR_SETUP 6'h01
`define ADDR_CAL 6'h02
`define ADDR_DRIFT 6'h03
`define ADDR_SHUNT_RES 6'h04
`define SETUP_RST 16'hfb68
`define CAL_RST 15'h1000
`define DRIFT_RST 14'h0000
`define RES_RST 20'h0_0000
`define RES_PAD 4'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MODE_CONT 15
`define MODE_TMP 14
`define MODE_CH_LO 12
`define BUS_CT_LO 9
`define SH_CT_LO 6
`define TMP_CT_LO 3
`define AVG_LO 0
`define CAL_MSB 14
`define DRIFT_MSB 13

// ----------------------------------------
// Channels and conversion times
// ----------------------------------------
`define CH_BUS 2'h0
`define CH_SHUNT 2'h1
`define CH_TEMP 2'h2
`define CH_NONE 2'h3
`define CLK_MHZ 200
`define CT0_US 50
`define CT1_US 84
`define CT2_US 150
`define CT3_US 280
`define CT4_US 540
`define CT5_US 1052
`define CT6_US 2074
`define CT7_US 4120

// Averaging counts as powers of two: 1,4,16,64,128,256,512,1024
`define AVG_SH0 4'h0
`define AVG_SH1 4'h2
`define AVG_SH2 4'h4
`define AVG_SH3 4'h6
`define AVG_SH4 4'h7
`define AVG_SH5 4'h8
`define AVG_SH6 4'h9
`define AVG_SH7 4'ha

`endif

// [verilog/pm_pkg.sv]
// Types shared by the measurement setup block
package pm_pkg;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_CONV = 2'b01,
        S_SAMPLE = 2'b10
    } state_t;
    typedef logic [1:0] chan_t;
endpackage : pm_pkg

// [verilog/conv_timer.sv]
// Down-counter that times one conversion
`timescale 1ns/1ps
module conv_timer #(
    parameter int W = 20
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic done_q
);
    logic [W-1:0] cnt_q;
    logic run_q;

    // A reload also drops a stale done, so a restart never sees an old finish
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (clk_en)
        begin
            done_q <= 1'b0;
            if (load)
            begin
                cnt_q <= load_val;
                run_q <= 1'b1;
            end
            else if (run_q)
            begin
                if (cnt_q <= W'(1))
                begin
                    run_q <= 1'b0;
                    done_q <= 1'b1;
                end
                else
                    cnt_q <= cnt_q - W'(1);
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst || !clk_en);

    a_timer_load: assert property (load |=> run_q && cnt_q == $past(load_val))
        else $error("conversion timer did not load");
    a_timer_pulse: assert property (done_q |=> !done_q)
        else $error("conversion done held longer than one cycle");
endmodule : conv_timer

// [verilog/adc_setup_regs.sv]
// Measurement setup, calibration, drift and shunt result registers
`timescale 1ns/1ps
`include "pm_consts.svh"
module adc_setup_regs #(
    parameter int TIMER_W = 20,
    parameter int unsigned CONV_CYC [0:7] = '{
        `CT0_US * `CLK_MHZ, `CT1_US * `CLK_MHZ,
        `CT2_US * `CLK_MHZ, `CT3_US * `CLK_MHZ,
        `CT4_US * `CLK_MHZ, `CT5_US * `CLK_MHZ,
        `CT6_US * `CLK_MHZ, `CT7_US * `CLK_MHZ}
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [23:0] reg_rdata_q,
    input wire logic shunt_range_select,
    input wire logic drift_correction_enable,
    input wire logic sample_valid,
    input wire logic [19:0] sample_data,
    output logic conv_start_q,
    output pm_pkg::chan_t conv_chan_q,
    output logic conv_range_q,
    output logic result_ready_q,
    output logic [19:0] bus_avg_q,
    output logic [19:0] temp_avg_q,
    output logic [14:0] scale_constant_q,
    output logic [13:0] drift_coeff_q
);
    import pm_pkg::*;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // Lowest enabled channel at or above start, none if there is none
    function automatic chan_t first_from(input logic [2:0] m, input logic [2:0] start);
        chan_t r;
        r = `CH_NONE;
        for (int i = 2; i >= 0; i--)
        begin
            if (m[i] && 3'(i) >= start)
                r = chan_t'(i);
        end
        return r;
    endfunction : first_from

    // Averaging count is always a power of two, so divide by shifting
    function automatic logic [3:0] avg_shift(input logic [2:0] sel);
        logic [3:0] s;
        case (sel)
            3'h0: s = `AVG_SH0;
            3'h1: s = `AVG_SH1;
            3'h2: s = `AVG_SH2;
            3'h3: s = `AVG_SH3;
            3'h4: s = `AVG_SH4;
            3'h5: s = `AVG_SH5;
            3'h6: s = `AVG_SH6;
            default: s = `AVG_SH7;
        endcase
        return s;
    endfunction : avg_shift

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic [15:0] setup_q;
    logic [14:0] cal_q;
    logic [13:0] drift_q;
    logic [19:0] res_q [0:2];
    logic signed [29:0] acc_q [0:2];
    state_t state_q;
    logic [10:0] round_q;
    logic timer_done;

    logic wr_setup;
    logic [2:0] mask;
    logic [2:0] new_mask;
    logic cont;
    logic [2:0] avg_sel;
    logic [3:0] shift;
    logic [10:0] rounds;
    logic last_round;
    logic sample_take;
    chan_t next_ch;
    chan_t first_ch;
    chan_t new_first;
    logic finish;
    logic [2:0] ct_sel;
    logic signed [29:0] sum_now;

    // Low three mode bits pick channels, the top bit picks continuous
    assign wr_setup = reg_wr && reg_addr == `ADDR_SETUP;
    assign mask = setup_q[`MODE_TMP:`MODE_CH_LO];
    assign new_mask = reg_wdata[`MODE_TMP:`MODE_CH_LO];
    assign cont = setup_q[`MODE_CONT];
    assign avg_sel = setup_q[`AVG_LO+2:`AVG_LO];
    assign shift = avg_shift(avg_sel);
    assign rounds = 11'h001 << shift;
    // Greater-or-equal so a smaller count written mid-run still ends it
    assign last_round = round_q >= rounds - 11'h001;
    assign sample_take = state_q == S_SAMPLE && sample_valid;
    assign next_ch = first_from(mask, 3'({1'b0, conv_chan_q}) + 3'h1);
    assign first_ch = first_from(mask, 3'h0);
    assign new_first = first_from(new_mask, 3'h0);
    assign finish = sample_take && next_ch == `CH_NONE && last_round;
    assign sum_now = acc_q[conv_chan_q] + 30'(signed'(sample_data));

    // Each channel has its own time code; all share one encoding
    always_comb
    begin
        case (conv_chan_q)
            `CH_BUS: ct_sel = setup_q[`BUS_CT_LO+2:`BUS_CT_LO];
            `CH_SHUNT: ct_sel = setup_q[`SH_CT_LO+2:`SH_CT_LO];
            default: ct_sel = setup_q[`TMP_CT_LO+2:`TMP_CT_LO];
        endcase
    end

    // ----------------------------------------
    // Writable registers
    // ----------------------------------------

    // Whole setup word is writable; mode write also restarts the sequence
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            setup_q <= `SETUP_RST;
        else if (clk_en && wr_setup)
            setup_q <= reg_wdata;
    end

    // Reserved top bits are never stored, so they cannot read back set
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cal_q <= `CAL_RST;
            drift_q <= `DRIFT_RST;
        end
        else if (clk_en && reg_wr)
        begin
            if (reg_addr == `ADDR_CAL)
                cal_q <= reg_wdata[`CAL_MSB:0];
            if (reg_addr == `ADDR_DRIFT)
                drift_q <= reg_wdata[`DRIFT_MSB:0];
        end
    end

    // Values handed to the arithmetic and front end
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            drift_coeff_q <= `DRIFT_RST;
            conv_range_q <= 1'b0;
        end
        else if (clk_en)
        begin
            // Zero coefficient means no correction, so gating is enough
            drift_coeff_q <= drift_correction_enable ? drift_q : `DRIFT_RST;
            conv_range_q <= shunt_range_select;
        end
    end
    assign scale_constant_q = cal_q;

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------

    // Channels run in order bus, shunt, temperature, once per averaging round
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= S_IDLE;
            conv_chan_q <= `CH_BUS;
            round_q <= '0;
            conv_start_q <= 1'b0;
            result_ready_q <= 1'b0;
        end
        else if (clk_en)
        begin
            conv_start_q <= 1'b0;
            result_ready_q <= 1'b0;
            if (wr_setup)
            begin
                round_q <= '0;
                if (new_first != `CH_NONE)
                begin
                    state_q <= S_CONV;
                    conv_chan_q <= new_first;
                    conv_start_q <= 1'b1;
                end
                else
                    state_q <= S_IDLE;
            end
            else
            begin
                case (state_q)
                    S_IDLE:
                        state_q <= S_IDLE;
                    S_CONV:
                        // A finish from an aborted conversion is not trusted
                        if (timer_done && !conv_start_q)
                            state_q <= S_SAMPLE;
                    S_SAMPLE:
                        if (sample_valid)
                        begin
                            if (next_ch != `CH_NONE)
                            begin
                                conv_chan_q <= next_ch;
                                state_q <= S_CONV;
                                conv_start_q <= 1'b1;
                            end
                            else if (!last_round)
                            begin
                                round_q <= round_q + 11'h001;
                                conv_chan_q <= first_ch;
                                state_q <= S_CONV;
                                conv_start_q <= 1'b1;
                            end
                            else
                            begin
                                result_ready_q <= 1'b1;
                                round_q <= '0;
                                if (cont)
                                begin
                                    conv_chan_q <= first_ch;
                                    state_q <= S_CONV;
                                    conv_start_q <= 1'b1;
                                end
                                else
                                    state_q <= S_IDLE;
                            end
                        end
                    default:
                        state_q <= S_IDLE;
                endcase
            end
        end
    end

    conv_timer #(
        .W(TIMER_W)
    ) u_timer (
        .clk(clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .load(conv_start_q),
        .load_val(TIMER_W'(CONV_CYC[ct_sel])),
        .done_q(timer_done)
    );

    // ----------------------------------------
    // Averaging and results
    // ----------------------------------------

    // Sums grow by up to ten bits; results change only at the finish
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int c = 0; c < 3; c++)
            begin
                acc_q[c] <= '0;
                res_q[c] <= `RES_RST;
            end
        end
        else if (clk_en)
        begin
            if (wr_setup)
            begin
                for (int c = 0; c < 3; c++)
                    acc_q[c] <= '0;
            end
            else if (finish)
            begin
                for (int c = 0; c < 3; c++)
                begin
                    acc_q[c] <= '0;
                    if (mask[c] && 2'(c) == conv_chan_q)
                        res_q[c] <= 20'(sum_now >>> shift);
                    else if (mask[c])
                        res_q[c] <= 20'(acc_q[c] >>> shift);
                end
            end
            else if (sample_take)
                acc_q[conv_chan_q] <= sum_now;
        end
    end
    assign bus_avg_q = res_q[`CH_BUS];
    assign temp_avg_q = res_q[`CH_TEMP];

    // ----------------------------------------
    // Read port
    // ----------------------------------------

    // Data appears the cycle after the read strobe; unmapped reads give zero
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata_q <= '0;
        else if (clk_en && reg_rd)
        begin
            case (reg_addr)
                `ADDR_SETUP: reg_rdata_q <= 24'(setup_q);
                `ADDR_CAL: reg_rdata_q <= 24'(cal_q);
                `ADDR_DRIFT: reg_rdata_q <= 24'(drift_q);
                `ADDR_SHUNT_RES: reg_rdata_q <= {res_q[`CH_SHUNT], `RES_PAD};
                default: reg_rdata_q <= '0;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst || !clk_en);

    a_shutdown_idle: assert property (mask == 3'h0 |-> state_q == S_IDLE && !conv_start_q)
        else $error("converter active in shutdown");
    a_chan_enabled: assert property (conv_start_q |-> mask[conv_chan_q])
        else $error("conversion started on a disabled channel");
    a_single_stop: assert property (
        result_ready_q && !cont && !wr_setup |-> state_q == S_IDLE ##1 !conv_start_q)
        else $error("single shot did not stop");
    a_cont_rerun: assert property (result_ready_q && cont |-> conv_start_q && state_q == S_CONV)
        else $error("continuous mode did not restart");
    a_result_hold: assert property (
        !$stable(res_q[`CH_SHUNT]) |-> result_ready_q)
        else $error("shunt result changed before averaging ended");
    a_cal_reserved: assert property (
        reg_rd && reg_addr == `ADDR_CAL |=> reg_rdata_q[23:15] == 9'h000)
        else $error("calibration reserved bits not zero");
    a_res_reserved: assert property (
        reg_rd && reg_addr == `ADDR_SHUNT_RES |=> reg_rdata_q[3:0] == `RES_PAD)
        else $error("result reserved bits not zero");
    a_drift_gate: assert property (!drift_correction_enable |=> drift_coeff_q == `DRIFT_RST)
        else $error("drift coefficient used while disabled");
    a_result_ro: assert property (
        reg_wr && reg_addr == `ADDR_SHUNT_RES && !finish |=> $stable(res_q[`CH_SHUNT]))
        else $error("write changed the shunt result");
    a_range_follow: assert property (
        $past(clk_en) |-> conv_range_q == $past(shunt_range_select))
        else $error("range select not passed on");

    c_single_done: cover property (result_ready_q && !cont);
    c_cont_done: cover property (result_ready_q && cont);
    c_avg_done: cover property (result_ready_q && avg_sel != 3'h0);
    c_restart: cover property (wr_setup && state_q == S_CONV);
endmodule : adc_setup_regs

// [sim/front_end_model.sv]
// Behavioural converter front end that answers the latest conversion start
`timescale 1ns/1ps
module front_end_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic conv_start,
    output logic sample_valid,
    output logic [19:0] sample_data
);
    int wait_q;

    // ----------------------------------------
    // Sample answer
    // ----------------------------------------
    // A new start cancels a pending answer, as an aborted conversion would.
    // The wait always exceeds the longest timer, with a random stall on top.
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_q <= 0;
            sample_valid <= 1'b0;
            sample_data <= 20'h5_a5a5;
        end
        else
        begin
            sample_valid <= 1'b0;
            sample_data <= ~sample_data; // Data is meaningless outside the pulse
            if (conv_start)
            begin
                wait_q <= 14 + $urandom_range(0, 9);
            end
            else if (wait_q == 1)
            begin
                wait_q <= 0;
                sample_valid <= 1'b1;
                sample_data <= 20'($urandom);
            end
            else if (wait_q != 0)
            begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule : front_end_model

// [sim/testbench.sv]
// Self-checking bench for the measurement setup register block
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic clk_en = 1'b1;
    logic shunt_range_select = 1'b0;
    logic drift_correction_enable = 1'b0;
    logic [23:0] reg_rdata_q;
    logic sample_valid;
    logic [19:0] sample_data;
    logic conv_start_q;
    logic [1:0] conv_chan_q;
    logic conv_range_q;
    logic result_ready_q;
    logic [19:0] bus_avg_q;
    logic [19:0] temp_avg_q;
    logic [14:0] scale_constant_q;
    logic [13:0] drift_coeff_q;
    logic signed [31:0] sum [3] = '{default: 32'sh0000_0000};
    logic [19:0] exp_res [3] = '{default: 20'h0_0000};
    logic [2:0] mask = 3'h0;
    logic [2:0] seen = 3'h0;
    logic [15:0] r;
    int k_sh = 0;
    int n_start = 0;
    int n_samp = 0;
    int n_ready = 0;
    int n_fail = 0;
    int checked = 0;

    always #2.5 clk = ~clk;

    // Short conversion times keep the run brief
    adc_setup_regs #(.CONV_CYC('{4, 5, 6, 7, 8, 9, 10, 11})) i_dut (
        .clk(clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .shunt_range_select(shunt_range_select),
        .drift_correction_enable(drift_correction_enable),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .conv_start_q(conv_start_q), .conv_chan_q(conv_chan_q), .conv_range_q(conv_range_q),
        .result_ready_q(result_ready_q), .bus_avg_q(bus_avg_q), .temp_avg_q(temp_avg_q),
        .scale_constant_q(scale_constant_q), .drift_coeff_q(drift_coeff_q));

    front_end_model i_model (.clk(clk), .nrst(nrst), .conv_start(conv_start_q),
        .sample_valid(sample_valid), .sample_data(sample_data));

    // ----------------------------------------
    // Expectation model
    // ----------------------------------------
    // Log2 of the averaging count for each code
    function automatic int sh(input logic [2:0] k);
        return (k < 3'h4) ? 2 * int'(k) : int'(k) + 3;
    endfunction : sh

    // Sums follow the samples; a setup write discards a partial average
    always @(posedge clk)
    begin
        if (conv_start_q)
        begin
            seen = seen | (3'h1 << conv_chan_q);
            n_start++;
        end
        if (sample_valid)
        begin
            sum[conv_chan_q] = sum[conv_chan_q] + 32'(signed'(sample_data));
            n_samp++;
        end
        if (result_ready_q)
        begin
            for (int c = 0; c < 3; c++)
            begin
                if (mask[c])
                    exp_res[c] = 20'(sum[c] >>> k_sh);
                sum[c] = 32'sh0000_0000;
            end
            n_ready++;
        end
        if (reg_wr && reg_addr == 6'h01)
        begin
            mask = reg_wdata[14:12];
            k_sh = sh(reg_wdata[2:0]);
            sum = '{default: 32'sh0000_0000};
        end
    end

    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
    endtask : wr

    // Read data is registered at the strobe edge and looked at just after it
    task automatic rd(input logic [5:0] a, input logic [23:0] exp);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        check(reg_rdata_q, exp, "read");
    endtask : rd

    // One setup write, then channels, counts, results and restart behaviour
    task automatic run(input logic [15:0] w);
        int lim;
        logic [2:0] m;
        m = w[14:12];
        seen = 3'h0;
        n_ready = 0;
        n_samp = 0;
        lim = 100 + 90 * (1 << sh(w[2:0]));
        wr(6'h01, w);
        while (n_ready == 0 && lim > 0)
        begin
            @(posedge clk);
            lim--;
        end
        #1;
        check(24'(seen), 24'(m), "channels");
        check(24'(n_ready), 24'(m != 3'h0), "ready count");
        check(24'(n_samp), 24'((1 << sh(w[2:0])) * $countones(m)), "samples");
        check(24'(bus_avg_q), 24'(exp_res[0]), "bus result");
        check(24'(temp_avg_q), 24'(exp_res[2]), "temp result");
        rd(6'h04, {exp_res[1], 4'h0});
        n_start = 0;
        repeat (60) @(posedge clk);
        #1;
        check(24'(n_start != 0), 24'(w[15] && m != 3'h0), "restart");
        rd(6'h01, {8'h00, w});
        wr(6'h01, 16'h0000);
        // A front end answer still in flight must drain before the next sequence
        repeat (30) @(posedge clk);
    endtask : run

    task automatic results;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (60000) @(posedge clk);
        n_fail++;
        $display("FAIL t=%0t watchdog expired", $time);
        results();
    end

    // Main sequence
    initial
    begin
        void'($urandom(83257));
        repeat (8) @(posedge clk);
        #1;
        nrst = 1'b1;
        rd(6'h01, 24'h00_fb68);
        rd(6'h02, 24'h00_1000);
        rd(6'h03, 24'h00_0000);
        rd(6'h04, 24'h00_0000);
        rd(6'h3f, 24'h00_0000);
        check(24'(scale_constant_q), 24'h00_1000, "cal reset");
        r = 16'($urandom);
        wr(6'h02, r | 16'h8000);
        rd(6'h02, {9'h000, r[14:0]});
        check(24'(scale_constant_q), 24'(r[14:0]), "cal out");
        wr(6'h03, 16'hffff);
        rd(6'h03, 24'h00_3fff);
        check(24'(drift_coeff_q), 24'h00_0000, "drift off");
        drift_correction_enable = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(24'(drift_coeff_q), 24'h00_3fff, "drift on");
        wr(6'h03, r | 16'hc000);
        rd(6'h03, {10'h000, r[13:0]});
        check(24'(drift_coeff_q), 24'(r[13:0]), "drift out");
        // A frozen block ignores a write and keeps its last read data
        clk_en = 1'b0;
        wr(6'h02, ~r);
        rd(6'h02, {10'h000, r[13:0]});
        clk_en = 1'b1;
        rd(6'h02, {9'h000, r[14:0]});
        wr(6'h04, 16'hffff);
        rd(6'h04, 24'h00_0000);
        for (int v = 1; v >= 0; v--)
        begin
            shunt_range_select = v[0];
            repeat (2) @(posedge clk);
            #1;
            check(24'(conv_range_q), 24'(v), "range");
        end
        // Every mode code once, with random conversion times
        for (int m = 0; m < 16; m++)
            run({m[3:0], 9'($urandom), 3'h0});
        // Averaging codes 3 and 1, then random single-shot runs
        run(16'h1003);
        run(16'h7001);
        for (int i = 0; i < 4; i++)
            run({1'b0, 3'($urandom_range(1, 7)), 9'($urandom), 3'($urandom_range(0, 2))});
        results();
    end
endmodule : testbench
